// ==== xbus_io_map.vh ====
// register indices, field positions and reset values of the x-bus i/o zone decoder
`ifndef XBUS_IO_MAP_VH
`define XBUS_IO_MAP_VH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define IDX_IO_ZONE_CONFIG 12'h0F0
`define IDX_IO_BASE1_HIGH 12'h0F1
`define IDX_IO_BASE1_LOW 12'h0F2
`define IDX_IO_ZONE_SIZE1 12'h0F3
`define IDX_IO_BASE2_HIGH 12'h0F4
`define IDX_IO_BASE2_LOW 12'h0F5
`define IDX_IO_ZONE_SIZE2 12'h0F6
`define IDX_SERIAL_BLOCK_CONTROL 12'h100
`define IDX_DECODE_STATUS 12'h101

// ------------------------------------------------------------
// io_zone_config fields
// ------------------------------------------------------------
`define CFG_ZONE_ENABLE_LSB 0
`define CFG_DEBUG_PORT_ENABLE_BIT 4
`define CFG_IO_MAP_LOCK_BIT 7
`define CFG_WRITABLE_MASK 8'h9F

// ------------------------------------------------------------
// serial_block_control fields
// ------------------------------------------------------------
`define SBC_LOCK_RESET_SOURCE_BIT 0
`define SBC_UNLOCK_REQUEST_BIT 1

// ------------------------------------------------------------
// size field and fixed zone
// ------------------------------------------------------------
`define SIZE_FIELD_MSB 3
`define SIZE_CODE_MAX 4'h8
`define DEBUG_PORT_ADDR 16'h0080

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RST_IO_ZONE_CONFIG 8'h00
`define RST_IO_BASE_BYTE 8'h00
`define RST_IO_ZONE_SIZE 8'h00
`define RST_SERIAL_BLOCK_CONTROL 8'h00

// ------------------------------------------------------------
// axi4-lite responses
// ------------------------------------------------------------
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// ==== sync_two_ff.v ====
// two flip-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module sync_two_ff #(
    parameter WIDTH = 2
) (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // levels
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;

    always @(posedge sys_clk) begin
        if (rst) begin
            stage1_reg <= {WIDTH{1'b0}};
            stage2_reg <= {WIDTH{1'b0}};
        end else begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;
endmodule
`default_nettype wire

// ==== io_zone_match.v ====
// address window compare for one user-defined i/o zone
`include "xbus_io_map.vh"
`timescale 1ns/100ps
`default_nettype none
module io_zone_match (
    // zone setup
    input wire enable,
    input wire [16:0] zoneBase,
    input wire [3:0] sizeCode,
    // address under test
    input wire [15:0] ioAddr,
    output wire hit
);
    wire [16:0] windowSize;
    wire [16:0] zoneTop;
    wire sizeLegal;

    // reserved size codes never match
    assign sizeLegal = (sizeCode <= `SIZE_CODE_MAX);
    assign windowSize = 17'h00001 << sizeCode;
    assign zoneTop = zoneBase + windowSize;
    assign hit = enable && sizeLegal && ({1'b0, ioAddr} >= zoneBase)
        && ({1'b0, ioAddr} < zoneTop);
endmodule
`default_nettype wire

// ==== xbus_io_zone_decoder.v ====
// x-bus i/o zone decoder: zone registers, map lock and lpc i/o address decode
`include "xbus_io_map.vh"
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// R1: while locked, writes to config, base and size registers are ignored, lock too
// R2: lock is cleared by main or standby power-up reset, chosen by a select bit
// R3: writing the unlock request bit clears the lock
// R4: lock resets to 0; when 1 every protected bit is read-only
// R5: debug-port enable in bit 4 forwards i/o address 80h; resets disabled
// R6: zone 0 starts at base 1 with size 1 when enable 0 is set
// R7: zone 1 starts at base 1 plus size 1, same size, enable 1
// R8: zone 2 starts at base 2 with size 2 when enable 2 is set
// R9: zone 3 starts at base 2 plus size 2, same size, enable 3
// R10: base 1 high byte holds upper address bits of zones 0 and 1, resets 00h
// R11: size field bits 3-0 give window of two to the n bytes, n 0 to 8
// R12: enabled zone without a chip select association gets no response
// R13: software aligns each base address to its zone size
// R14: zone select asserts for base at or below address below base plus size
// R15: config bits 6 and 5 read zero and ignore writes
module xbus_io_zone_decoder #(
    parameter ADDR_W = 12
) (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // power-up reset levels from outside the clock domain
    input wire mainPowerResetIn,
    input wire standbyPowerResetIn,
    // axi4-lite write address
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    // axi4-lite write data
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    // axi4-lite write response
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    output wire [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    // axi4-lite read data
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    // lpc i/o cycle from the host interface logic
    input wire lpcIoValid,
    input wire [15:0] lpcIoAddr,
    // chip select association per select: zones 0-3, debug port in bit 4
    input wire [4:0] selectAssociated,
    // selects toward the x-bus block
    output wire [3:0] zoneSelect,
    output wire debugPortSelect,
    output wire xbusForward
);

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam [ADDR_W-1:0] ADDR_CONFIG = `IDX_IO_ZONE_CONFIG << 2;
    localparam [ADDR_W-1:0] ADDR_BASE1_HIGH = `IDX_IO_BASE1_HIGH << 2;
    localparam [ADDR_W-1:0] ADDR_BASE1_LOW = `IDX_IO_BASE1_LOW << 2;
    localparam [ADDR_W-1:0] ADDR_SIZE1 = `IDX_IO_ZONE_SIZE1 << 2;
    localparam [ADDR_W-1:0] ADDR_BASE2_HIGH = `IDX_IO_BASE2_HIGH << 2;
    localparam [ADDR_W-1:0] ADDR_BASE2_LOW = `IDX_IO_BASE2_LOW << 2;
    localparam [ADDR_W-1:0] ADDR_SIZE2 = `IDX_IO_ZONE_SIZE2 << 2;
    localparam [ADDR_W-1:0] ADDR_SERIAL_CTRL = `IDX_SERIAL_BLOCK_CONTROL << 2;
    localparam [ADDR_W-1:0] ADDR_STATUS = `IDX_DECODE_STATUS << 2;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    reg ioMapLock_reg;
    reg [3:0] zoneEnable_reg;
    reg debugPortDecodeEnable_reg;
    reg [7:0] ioBase1HighByte_reg;
    reg [7:0] ioBase1LowByte_reg;
    reg [3:0] ioZoneSize1_reg;
    reg [7:0] ioBase2HighByte_reg;
    reg [7:0] ioBase2LowByte_reg;
    reg [3:0] ioZoneSize2_reg;
    reg lockResetSourceSelect_reg;

    // ------------------------------------------------------------
    // axi channel state
    // ------------------------------------------------------------
    reg awHeld_reg;
    reg [ADDR_W-1:0] awAddr_reg;
    reg wHeld_reg;
    reg [7:0] wByte_reg;
    reg wLaneOn_reg;
    reg bValid_reg;
    reg [1:0] bResp_reg;
    reg rValid_reg;
    reg [31:0] rData_reg;
    reg [1:0] rResp_reg;

    // ------------------------------------------------------------
    // decode state
    // ------------------------------------------------------------
    reg [3:0] zoneSelect_reg;
    reg debugPortSelect_reg;
    reg xbusForward_reg;
    reg [4:0] lastHit_reg;

    wire [1:0] powerResetSync;
    wire mainPowerReset;
    wire standbyPowerReset;
    wire lockClearByReset;
    wire writeFire;
    wire writeLane;
    wire cfgWrite;
    wire protectedWrite;
    wire unlockRequest;
    wire lockSet;
    wire mapWritable;
    wire [16:0] base1;
    wire [16:0] base2;
    wire [16:0] size1Bytes;
    wire [16:0] size2Bytes;
    wire [16:0] zoneBase [0:3];
    wire [3:0] zoneSizeCode [0:3];
    wire [3:0] zoneHit;
    wire debugHit;
    wire [7:0] configRead;
    reg [31:0] readWord;
    reg readMapped;
    reg writeMapped;

    // ------------------------------------------------------------
    // power-up reset synchronisation
    // ------------------------------------------------------------
    sync_two_ff #(
        .WIDTH(2)
    ) powerResetSyncInst (
        .sys_clk(sys_clk),
        .rst(rst),
        .asyncIn({standbyPowerResetIn, mainPowerResetIn}),
        .syncOut(powerResetSync)
    );

    assign mainPowerReset = powerResetSync[0];
    assign standbyPowerReset = powerResetSync[1];
    // select 0 picks the main supply reset, 1 the standby reset
    assign lockClearByReset = lockResetSourceSelect_reg ? standbyPowerReset
        : mainPowerReset; // [R2]

    // ------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------
    assign s_axi_awready = !awHeld_reg && !bValid_reg;
    assign s_axi_wready = !wHeld_reg && !bValid_reg;
    assign s_axi_bvalid = bValid_reg;
    assign s_axi_bresp = bResp_reg;
    assign writeFire = awHeld_reg && wHeld_reg && !bValid_reg;
    assign writeLane = writeFire && wLaneOn_reg;

    always @(posedge sys_clk) begin
        if (rst) begin
            awHeld_reg <= 1'b0;
            awAddr_reg <= {ADDR_W{1'b0}};
            wHeld_reg <= 1'b0;
            wByte_reg <= 8'h00;
            wLaneOn_reg <= 1'b0;
            bValid_reg <= 1'b0;
            bResp_reg <= `AXI_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wByte_reg <= s_axi_wdata[7:0];
                wLaneOn_reg <= s_axi_wstrb[0];
            end
            if (writeFire) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                bValid_reg <= 1'b1;
                bResp_reg <= writeMapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (bValid_reg && s_axi_bready) begin
                bValid_reg <= 1'b0;
            end
        end
    end

    always @* begin
        case ({awAddr_reg[ADDR_W-1:2], 2'b00})
            ADDR_CONFIG, ADDR_BASE1_HIGH, ADDR_BASE1_LOW, ADDR_SIZE1,
            ADDR_BASE2_HIGH, ADDR_BASE2_LOW, ADDR_SIZE2,
            ADDR_SERIAL_CTRL, ADDR_STATUS: writeMapped = 1'b1;
            default: writeMapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // lock control
    // ------------------------------------------------------------
    assign mapWritable = !ioMapLock_reg; // [R4]
    assign cfgWrite = writeLane && (awAddr_reg[ADDR_W-1:2] == ADDR_CONFIG[ADDR_W-1:2]);
    // protected registers take writes only while unlocked
    assign protectedWrite = writeLane && mapWritable; // [R1]
    assign unlockRequest = writeLane
        && (awAddr_reg[ADDR_W-1:2] == ADDR_SERIAL_CTRL[ADDR_W-1:2])
        && wByte_reg[`SBC_UNLOCK_REQUEST_BIT]; // [R3]
    assign lockSet = cfgWrite && mapWritable && wByte_reg[`CFG_IO_MAP_LOCK_BIT];

    always @(posedge sys_clk) begin
        if (rst) begin
            ioMapLock_reg <= 1'b0; // [R4]
        end else if (lockSet) begin
            // a set in the same cycle as a clear wins
            ioMapLock_reg <= 1'b1;
        end else if (lockClearByReset || unlockRequest) begin
            ioMapLock_reg <= 1'b0; // [R2] [R3]
        end
    end

    // ------------------------------------------------------------
    // protected map registers
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rst) begin
            zoneEnable_reg <= 4'h0; // [R6] [R7] [R8] [R9]
            debugPortDecodeEnable_reg <= 1'b0; // [R5]
            ioBase1HighByte_reg <= `RST_IO_BASE_BYTE; // [R10]
            ioBase1LowByte_reg <= `RST_IO_BASE_BYTE;
            ioZoneSize1_reg <= 4'h0;
            ioBase2HighByte_reg <= `RST_IO_BASE_BYTE;
            ioBase2LowByte_reg <= `RST_IO_BASE_BYTE;
            ioZoneSize2_reg <= 4'h0;
        end else if (protectedWrite) begin // [R1]
            case ({awAddr_reg[ADDR_W-1:2], 2'b00})
                ADDR_CONFIG: begin
                    zoneEnable_reg <= wByte_reg[`CFG_ZONE_ENABLE_LSB +: 4];
                    debugPortDecodeEnable_reg <= wByte_reg[`CFG_DEBUG_PORT_ENABLE_BIT];
                end
                ADDR_BASE1_HIGH: ioBase1HighByte_reg <= wByte_reg; // [R10]
                ADDR_BASE1_LOW: ioBase1LowByte_reg <= wByte_reg;
                ADDR_SIZE1: ioZoneSize1_reg <= wByte_reg[`SIZE_FIELD_MSB:0]; // [R11]
                ADDR_BASE2_HIGH: ioBase2HighByte_reg <= wByte_reg;
                ADDR_BASE2_LOW: ioBase2LowByte_reg <= wByte_reg;
                ADDR_SIZE2: ioZoneSize2_reg <= wByte_reg[`SIZE_FIELD_MSB:0]; // [R11]
                default: ioBase2LowByte_reg <= ioBase2LowByte_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // serial block control (never locked)
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (rst) begin
            lockResetSourceSelect_reg <= 1'b0;
        end else if (writeLane
            && (awAddr_reg[ADDR_W-1:2] == ADDR_SERIAL_CTRL[ADDR_W-1:2])) begin
            lockResetSourceSelect_reg <= wByte_reg[`SBC_LOCK_RESET_SOURCE_BIT];
        end
    end

    // ------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------
    assign configRead = {ioMapLock_reg, 2'b00, debugPortDecodeEnable_reg,
        zoneEnable_reg}; // [R15]

    always @* begin
        readWord = 32'h00000000;
        readMapped = 1'b1;
        case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
            ADDR_CONFIG: readWord[7:0] = configRead;
            ADDR_BASE1_HIGH: readWord[7:0] = ioBase1HighByte_reg;
            ADDR_BASE1_LOW: readWord[7:0] = ioBase1LowByte_reg;
            ADDR_SIZE1: readWord[3:0] = ioZoneSize1_reg;
            ADDR_BASE2_HIGH: readWord[7:0] = ioBase2HighByte_reg;
            ADDR_BASE2_LOW: readWord[7:0] = ioBase2LowByte_reg;
            ADDR_SIZE2: readWord[3:0] = ioZoneSize2_reg;
            // unlock request reads back as zero
            ADDR_SERIAL_CTRL: readWord[0] = lockResetSourceSelect_reg;
            ADDR_STATUS: readWord[5:0] = {ioMapLock_reg, lastHit_reg};
            default: readMapped = 1'b0;
        endcase
    end

    assign s_axi_arready = !rValid_reg;
    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rdata = rData_reg;
    assign s_axi_rresp = rResp_reg;

    always @(posedge sys_clk) begin
        if (rst) begin
            rValid_reg <= 1'b0;
            rData_reg <= 32'h00000000;
            rResp_reg <= `AXI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rValid_reg <= 1'b1;
            rData_reg <= readWord;
            rResp_reg <= readMapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (rValid_reg && s_axi_rready) begin
            rValid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // zone geometry
    // ------------------------------------------------------------
    // alignment of each base to its size is left to software [R13]
    assign base1 = {1'b0, ioBase1HighByte_reg, ioBase1LowByte_reg}; // [R10]
    assign base2 = {1'b0, ioBase2HighByte_reg, ioBase2LowByte_reg};
    assign size1Bytes = 17'h00001 << ioZoneSize1_reg; // [R11]
    assign size2Bytes = 17'h00001 << ioZoneSize2_reg; // [R11]
    assign zoneBase[0] = base1; // [R6]
    assign zoneBase[1] = base1 + size1Bytes; // [R7]
    assign zoneBase[2] = base2; // [R8]
    assign zoneBase[3] = base2 + size2Bytes; // [R9]
    assign zoneSizeCode[0] = ioZoneSize1_reg;
    assign zoneSizeCode[1] = ioZoneSize1_reg;
    assign zoneSizeCode[2] = ioZoneSize2_reg;
    assign zoneSizeCode[3] = ioZoneSize2_reg;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    genvar z;
    generate
        for (z = 0; z < 4; z = z + 1) begin : zoneGen
            io_zone_match zoneMatchInst (
                .enable(zoneEnable_reg[z] && selectAssociated[z]), // [R12]
                .zoneBase(zoneBase[z]),
                .sizeCode(zoneSizeCode[z]),
                .ioAddr(lpcIoAddr),
                .hit(zoneHit[z])
            ); // [R14]
        end
    endgenerate

    assign debugHit = debugPortDecodeEnable_reg && selectAssociated[4]
        && (lpcIoAddr == `DEBUG_PORT_ADDR); // [R5] [R12]

    always @(posedge sys_clk) begin
        if (rst) begin
            zoneSelect_reg <= 4'h0;
            debugPortSelect_reg <= 1'b0;
            xbusForward_reg <= 1'b0;
            lastHit_reg <= 5'h00;
        end else begin
            zoneSelect_reg <= lpcIoValid ? zoneHit : 4'h0; // [R14]
            debugPortSelect_reg <= lpcIoValid && debugHit; // [R5]
            xbusForward_reg <= lpcIoValid && ((|zoneHit) || debugHit);
            if (lpcIoValid && ((|zoneHit) || debugHit)) begin
                lastHit_reg <= {debugHit, zoneHit};
            end
        end
    end

    assign zoneSelect = zoneSelect_reg;
    assign debugPortSelect = debugPortSelect_reg;
    assign xbusForward = xbusForward_reg;

endmodule
`default_nettype wire

// ==== xbus_io_zone_decoder_checker.sv ====
// assertions on the ports of the x-bus i/o zone decoder
`timescale 1ns/100ps
`default_nettype none
module xbus_io_zone_decoder_checker (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // axi4-lite handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    // decode
    input wire lpcIoValid,
    input wire [15:0] lpcIoAddr,
    input wire [4:0] selectAssociated,
    input wire [3:0] zoneSelect,
    input wire debugPortSelect,
    input wire xbusForward
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_zone_cause: assert property (|zoneSelect |-> $past(lpcIoValid))
        else $error("zone select without an i/o cycle");
    a_zone_assoc: assert property ((zoneSelect & ~$past(selectAssociated[3:0])) == 4'h0)
        else $error("zone select for a zone without chip select");
    a_debug_addr: assert property (debugPortSelect |->
        $past(lpcIoValid) && $past(lpcIoAddr) == 16'h0080 && $past(selectAssociated[4]))
        else $error("debug select on a wrong cycle");
    a_fwd_any: assert property (xbusForward == (|zoneSelect || debugPortSelect))
        else $error("forward differs from the selects");
    a_pair_low: assert property (!(zoneSelect[0] && zoneSelect[1]))
        else $error("zones 0 and 1 overlap");
    a_pair_high: assert property (!(zoneSelect[2] && zoneSelect[3]))
        else $error("zones 2 and 3 overlap");
    a_zone_pulse: assert property (|zoneSelect && !lpcIoValid |=> zoneSelect == 4'h0)
        else $error("zone select longer than one cycle");
    a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read data late");

    c_debug: cover property (debugPortSelect);
    c_zone3: cover property (zoneSelect[3]);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
`default_nettype wire

// ==== lpc_host_model.sv ====
// lpc host model: issues one-cycle i/o cycles toward the decoder
`timescale 1ns/100ps
`default_nettype none
module lpc_host_model (
    // clock
    input wire logic sys_clk,
    // request from the bench
    input wire logic go,
    input wire logic [15:0] goAddr,
    // lpc i/o cycle
    output logic lpcIoValid,
    output logic [15:0] lpcIoAddr
);
    initial begin
        lpcIoValid = 1'b0;
        lpcIoAddr = 16'h0000;
    end
    // outside a cycle the address flips to the inverse of its last value on every clock, so it shows the old address again every second clock
    always @(posedge sys_clk) begin
        lpcIoValid <= go;
        lpcIoAddr <= go ? goAddr : ~lpcIoAddr;
    end
endmodule
`default_nettype wire

// ==== test_xbus_io_zone_decoder.sv ====
// self-checking testbench of the x-bus i/o zone decoder
`timescale 1ns/100ps
`default_nettype none
module test_xbus_io_zone_decoder;
    logic sys_clk, rst, mainPowerResetIn, standbyPowerResetIn, go;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, d;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [3:0] s_axi_wstrb;
    logic [4:0] selectAssociated;
    logic [15:0] goAddr;
    logic [1:0] r;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire lpcIoValid, debugPortSelect, xbusForward;
    wire [15:0] lpcIoAddr;
    wire [3:0] zoneSelect;
    integer failures, check_count, i;
    // address and expected {forward, debug, zones 3..0}
    logic [21:0] rows [0:12] = '{{16'h02FF, 6'h00}, {16'h0300, 6'h21}, {16'h0307, 6'h21},
        {16'h0308, 6'h22}, {16'h030F, 6'h22}, {16'h0310, 6'h00}, {16'h1000, 6'h24},
        {16'h10FF, 6'h24}, {16'h1100, 6'h28}, {16'h11FF, 6'h28}, {16'h1200, 6'h00},
        {16'h0080, 6'h30}, {16'h0081, 6'h00}};

    xbus_io_zone_decoder #(.ADDR_W(12)) xbus_io_zone_decoder_inst (.*);
    lpc_host_model lpc_host_model_inst (.*);

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic chkReg(input [31:0] g, input [31:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chkSel(input [5:0] g, input [5:0] e);
        chkReg({26'h0, g}, {26'h0, e});
    endtask
    task automatic guard(input integer n);
        if (n > 40) begin
            failures++;
            results();
        end
    endtask
    task automatic wr(input [11:0] a, input [7:0] v, output [1:0] rs);
        integer n;
        logic ta, tw, tb;
        begin
            @(posedge sys_clk);
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h0, v};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            n = 0;
            tb = 1'b0;
            while (!tb) begin
                @(negedge sys_clk);
                ta = s_axi_awvalid && s_axi_awready;
                tw = s_axi_wvalid && s_axi_wready;
                tb = s_axi_bvalid === 1'b1;
                rs = s_axi_bresp;
                @(posedge sys_clk);
                if (ta) s_axi_awvalid <= 1'b0;
                if (tw) s_axi_wvalid <= 1'b0;
                n++;
                guard(n);
            end
            s_axi_bready <= 1'b0;
        end
    endtask
    task automatic rd(input [11:0] a, output [31:0] v, output [1:0] rs);
        integer n;
        logic ta, tv;
        begin
            @(posedge sys_clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            n = 0;
            tv = 1'b0;
            while (!tv) begin
                @(negedge sys_clk);
                ta = s_axi_arvalid && s_axi_arready;
                tv = s_axi_rvalid === 1'b1;
                v = s_axi_rdata;
                rs = s_axi_rresp;
                @(posedge sys_clk);
                if (ta) s_axi_arvalid <= 1'b0;
                n++;
                guard(n);
            end
            s_axi_rready <= 1'b0;
        end
    endtask
    task automatic wrOk(input [11:0] a, input [7:0] v);
        wr(a, v, r);
        chkReg({30'h0, r}, 32'h0);
    endtask
    task automatic rdChk(input [11:0] a, input [31:0] e);
        rd(a, d, r);
        chkReg(d, e);
        chkReg({30'h0, r}, 32'h0);
    endtask
    task automatic lpc(input [15:0] a, input [4:0] m, input [5:0] e);
        @(posedge sys_clk);
        go <= 1'b1;
        goAddr <= a;
        selectAssociated <= m;
        @(posedge sys_clk);
        go <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chkSel({xbusForward, debugPortSelect, zoneSelect}, e);
    endtask
    task automatic pwr(input logic m, input logic sb);
        @(posedge sys_clk);
        mainPowerResetIn <= m;
        standbyPowerResetIn <= sb;
        repeat (6) @(posedge sys_clk);
        mainPowerResetIn <= 1'b0;
        standbyPowerResetIn <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic results;
        if (failures == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock and main sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        failures = 0;
        check_count = 0;
        {rst, mainPowerResetIn, standbyPowerResetIn, go, goAddr} = {4'h8, 16'h0};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00F;
        selectAssociated = 5'h1F;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        for (i = 0; i < 7; i++) rdChk(12'h3C0 + 12'(4 * i), 32'h0);
        lpc(16'h0000, 5'h1F, 6'h00);
        lpc(16'h0080, 5'h1F, 6'h00);
        wr(12'h3E0, 8'h11, r);
        chkReg({30'h0, r}, 32'h2);
        rd(12'h3E0, d, r);
        chkReg(d, 32'h0);
        chkReg({30'h0, r}, 32'h2);
        wrOk(12'h3C4, 8'h03);
        wrOk(12'h3CC, 8'h03);
        wrOk(12'h3D0, 8'h10);
        wrOk(12'h3D8, 8'h08);
        wrOk(12'h3C0, 8'h7F);
        rdChk(12'h3C0, 32'h1F);
        rdChk(12'h3C4, 32'h03);
        for (i = 0; i < 13; i++) lpc(rows[i][21:6], 5'h1F, rows[i][5:0]);
        lpc(16'h0300, 5'h1E, 6'h00);
        lpc(16'h0080, 5'h0F, 6'h00);
        wrOk(12'h3C0, 8'h0A);
        lpc(16'h0300, 5'h1F, 6'h00);
        lpc(16'h1100, 5'h1F, 6'h28);
        wrOk(12'h3C0, 8'h8A);
        rdChk(12'h3C0, 32'h8A);
        wrOk(12'h3C4, 8'h55);
        rdChk(12'h3C4, 32'h03);
        wrOk(12'h3D8, 8'h00);
        rdChk(12'h3D8, 32'h08);
        wrOk(12'h3C0, 8'h00);
        rdChk(12'h3C0, 32'h8A);
        lpc(16'h1100, 5'h1F, 6'h28);
        rdChk(12'h404, 32'h28);
        wrOk(12'h400, 8'h02);
        rdChk(12'h3C0, 32'h0A);
        rdChk(12'h400, 32'h0);
        wrOk(12'h3C0, 8'h8A);
        pwr(1'b0, 1'b1);
        rdChk(12'h3C0, 32'h8A);
        pwr(1'b1, 1'b0);
        rdChk(12'h3C0, 32'h0A);
        wrOk(12'h400, 8'h01);
        wrOk(12'h3C0, 8'h8A);
        pwr(1'b1, 1'b0);
        rdChk(12'h3C0, 32'h8A);
        pwr(1'b0, 1'b1);
        rdChk(12'h3C0, 32'h0A);
        wrOk(12'h3CC, 8'h09);
        lpc(16'h0308, 5'h1F, 6'h00);
        wrOk(12'h3CC, 8'h00);
        lpc(16'h0301, 5'h1F, 6'h22);
        lpc(16'h0302, 5'h1F, 6'h00);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rdChk(12'h3C0, 32'h0);
        results();
    end
endmodule
bind xbus_io_zone_decoder xbus_io_zone_decoder_checker xbus_io_zone_decoder_checker_inst (.*);
`default_nettype wire
